//--- src/current_cmd_regs.vh
// Constants for the current setpoint and measurement command block.
`ifndef CURRENT_CMD_REGS_VH
`define CURRENT_CMD_REGS_VH
// Register addresses.
`define ADDR_SETPOINT    4'h0
`define ADDR_UPPER       4'h1
`define ADDR_LOWER       4'h2
`define ADDR_LEGACY      4'h3
`define ADDR_MEAS_NOW    4'h4
`define ADDR_MAX         4'h5
`define ADDR_MIN         4'h6
`define ADDR_CAPTURE     4'h7
`define ADDR_FILTER      4'h8
`define ADDR_ERR_STATUS  4'h9
`define ADDR_ERR_MASK    4'hA
`define ADDR_CONTROL     4'hB
`define ADDR_VOLT_NOW    4'hC
`define ADDR_VMAX        4'hD
`define ADDR_VMIN        4'hE
// Values in milliamperes; nominal current of the lowest-rated model.
`define I_NOM            20'h0EA60
`define SET_RES          20'h00001
`define MEAS_STEP        18'h00002
`define MEAS_MAX         18'h17FFC
`define MEAS_MIN_MAG     18'h07FFE
`define OVER_CODE        20'hF423F
`define UNDER_CODE       20'h0BDC1
// Status and field positions.
`define ST_CMDERR        2
`define ST_OVER          0
`define ST_UNDER         1
`define CAP_ON           2'h1
`define CAP_RST          2'h2
`define CTRL_ANALOG      0
`define CTRL_IFC         1
`define FILT_RESET       3'h3
`define FILT_MIN         3'h1
`define FILT_MAX         3'h4
// Filter time constants in milliseconds and cycles per millisecond.
`define TC1_MS           1
`define TC2_MS           10
`define TC3_MS           50
`define TC4_MS           400
`define CLK_KHZ          20000
`define MS_LAST          15'h4E1F
`endif

//--- src/meas_lowpass.v
// First-order low-pass filter for one measured quantity.
`timescale 1ns/1ps
`include "current_cmd_regs.vh"
module meas_lowpass (
  input  wire               clk,
  input  wire               rst_n,
  input  wire               tick,
  input  wire [2:0]         sel,
  input  wire signed [17:0] raw,
  output reg  signed [17:0] filtered
);
  reg signed [33:0] acc;
  reg        [3:0]  shift;
  wire signed [35:0] diff;
  wire signed [35:0] step;
  // Each step is one millisecond; a shift approximates the time constant.
  always @* begin
    case (sel)
      3'h1:    shift = 4'h0;
      3'h2:    shift = 4'h3;
      3'h3:    shift = 4'h6;
      default: shift = 4'h9;
    endcase
  end
  assign diff = raw - (acc >>> 16);
  assign step = acc + ((diff <<< 16) >>> shift);
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      acc      <= 34'h000000000;
      filtered <= 18'h00000;
    end else if (tick) begin
      acc      <= step[33:0];
      filtered <= acc[33:16];
    end
  end
endmodule

//--- src/current_setpoint_cmds.v
// Current setpoint, soft bounds, measurement readback and filter select.
`timescale 1ns/1ps
`include "current_cmd_regs.vh"
// Functional notes
// - Interface clear leaves all stored state unchanged.
// - Upper bound between setpoint and nominal.
// - Lower bound between zero and setpoint.
// - Setpoint accepted only within both bounds.
// - Out-of-range value rejected, command error bit 2.
// - Accepted values rounded to setting resolution.
// - Bounds ignored under external analog control.
// - Legacy limit name writes upper bound.
// - Legacy limit query answers with upper bound.
// - Setpoint query returns selected setpoint.
// - Maximum query returns highest captured current.
// - Overrange latched, maximum reads positive overflow.
// - Minimum query returns lowest captured current.
// - Underrange latched, minimum reads negative overflow.
// - Capture reset loads all four extremes.
// - Present current query with overflow codes.
// - Filter select one to four, both quantities.
// - Extremes frozen while capture disabled.
module current_setpoint_cmds (
  input  wire               clk,
  input  wire               rst_n,
  input  wire [3:0]         addr,
  input  wire [31:0]        wrData,
  input  wire               wrStrobe,
  input  wire               rdStrobe,
  output reg  [31:0]        rdData,
  input  wire signed [17:0] currentRaw,
  input  wire signed [17:0] voltageRaw,
  input  wire               currentOverRange,
  input  wire               currentUnderRange,
  input  wire               interfaceClear,
  output reg  [19:0]        currentSetpoint,
  output reg                analogControl,
  output reg                interfaceReinit,
  output wire               irq
);
  // ---------------------------------------------------------------
  // Declarations
  // ---------------------------------------------------------------
  reg  [19:0]        upperBound;
  reg  [19:0]        lowerBound;
  reg                captureOn;
  reg  [2:0]         filterSel;
  reg  [2:0]         errStatus;
  reg  [2:0]         errMask;
  reg  signed [17:0] iMax;
  reg  signed [17:0] iMin;
  reg  signed [17:0] uMax;
  reg  signed [17:0] uMin;
  reg                overLatched;
  reg                underLatched;
  reg  [14:0]        msCount;
  reg                msTick;
  reg  [2:0]         next_errStatus;
  wire signed [17:0] iFilt;
  wire signed [17:0] uFilt;
  wire [19:0]        value;
  wire               isWrite;
  wire               boundsOff;
  wire               capReset;
  reg                setErr;
  reg                overEvent;
  reg                underEvent;

  // ---------------------------------------------------------------
  // Helper functions
  // ---------------------------------------------------------------
  // Rounds a milliampere value to the setting resolution.
  function [19:0] roundRes;
    input [19:0] v;
    begin
      roundRes = ((v + (`SET_RES >> 1)) / `SET_RES) * `SET_RES;
    end
  endfunction

  // Inclusive range test.
  function inRange;
    input [19:0] v;
    input [19:0] lo;
    input [19:0] hi;
    begin
      inRange = (v >= lo) && (v <= hi);
    end
  endfunction

  // Sign-extends a measured value to the bus width.
  function [31:0] ext;
    input signed [17:0] v;
    begin
      ext = {{14{v[17]}}, v};
    end
  endfunction

  // Upper bound and its legacy alias share one register.
  function isUpperAddr;
    input [3:0] a;
    begin
      isUpperAddr = (a == `ADDR_UPPER) || (a == `ADDR_LEGACY);
    end
  endfunction

  // Picks an overflow code or the sign-extended measured value.
  function [31:0] rangeWord;
    input               over;
    input               under;
    input signed [17:0] v;
    begin
      if (over) begin
        rangeWord = {12'h000, `OVER_CODE};
      end else if (under) begin
        rangeWord = {12'hFFF, `UNDER_CODE};
      end else begin
        rangeWord = ext(v);
      end
    end
  endfunction

  assign value     = roundRes(wrData[19:0]);
  assign isWrite   = wrStrobe;
  assign boundsOff = analogControl;
  assign capReset  = isWrite && (addr == `ADDR_CAPTURE) && wrData[1];

  // ---------------------------------------------------------------
  // Millisecond tick and filters
  // ---------------------------------------------------------------
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      msCount <= 15'h0000;
      msTick  <= 1'b0;
    end else if (msCount == `MS_LAST) begin
      msCount <= 15'h0000;
      msTick  <= 1'b1;
    end else begin
      msCount <= msCount + 15'h0001;
      msTick  <= 1'b0;
    end
  end

  meas_lowpass iFilter (
    .clk      (clk),
    .rst_n    (rst_n),
    .tick     (msTick),
    .sel      (filterSel),
    .raw      (currentRaw),
    .filtered (iFilt)
  );

  meas_lowpass uFilter (
    .clk      (clk),
    .rst_n    (rst_n),
    .tick     (msTick),
    .sel      (filterSel),
    .raw      (voltageRaw),
    .filtered (uFilt)
  );

  // ---------------------------------------------------------------
  // Setpoint and bounds
  // ---------------------------------------------------------------
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      currentSetpoint <= 20'h00000;
      upperBound      <= `I_NOM;
      lowerBound      <= 20'h00000;
      analogControl   <= 1'b0;
      captureOn       <= 1'b0;
      filterSel       <= `FILT_RESET;
      errMask         <= 3'h0;
      setErr          <= 1'b0;
    end else begin
      setErr <= 1'b0;
      if (isWrite) begin
        if (addr == `ADDR_SETPOINT) begin
          if (boundsOff ? inRange(value, 20'h00000, `I_NOM)
              : inRange(value, lowerBound, upperBound)) begin
            currentSetpoint <= value;
          end else begin
            setErr <= 1'b1;
          end
        end else if (isUpperAddr(addr)) begin
          if (inRange(value, currentSetpoint, `I_NOM)) begin
            upperBound <= value;
          end else begin
            setErr <= 1'b1;
          end
        end else if (addr == `ADDR_LOWER) begin
          if (inRange(value, 20'h00000, currentSetpoint)) begin
            lowerBound <= value;
          end else begin
            setErr <= 1'b1;
          end
        end else if (addr == `ADDR_CAPTURE) begin
          captureOn <= wrData[0];
        end else if (addr == `ADDR_FILTER) begin
          if (wrData[2:0] >= `FILT_MIN && wrData[2:0] <= `FILT_MAX) begin
            filterSel <= wrData[2:0];
          end else begin
            setErr <= 1'b1;
          end
        end else if (addr == `ADDR_ERR_MASK) begin
          errMask <= wrData[2:0];
        end else if (addr == `ADDR_CONTROL) begin
          analogControl <= wrData[`CTRL_ANALOG];
        end
      end
    end
  end

  // ---------------------------------------------------------------
  // Interface clear
  // ---------------------------------------------------------------
  // Only the bus interface is reinitialised; no stored value is touched.
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      interfaceReinit <= 1'b0;
    end else begin
      interfaceReinit <= interfaceClear;
    end
  end

  // ---------------------------------------------------------------
  // Extremes capture
  // ---------------------------------------------------------------
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      iMax         <= 18'h00000;
      iMin         <= 18'h00000;
      uMax         <= 18'h00000;
      uMin         <= 18'h00000;
      overLatched  <= 1'b0;
      underLatched <= 1'b0;
      overEvent    <= 1'b0;
      underEvent   <= 1'b0;
    end else begin
      overEvent  <= 1'b0;
      underEvent <= 1'b0;
      if (capReset) begin
        iMax         <= iFilt;
        iMin         <= iFilt;
        uMax         <= uFilt;
        uMin         <= uFilt;
        overLatched  <= 1'b0;
        underLatched <= 1'b0;
      end else if (captureOn) begin
        if (iFilt > iMax) begin
          iMax <= iFilt;
        end
        if (iFilt < iMin) begin
          iMin <= iFilt;
        end
        if (uFilt > uMax) begin
          uMax <= uFilt;
        end
        if (uFilt < uMin) begin
          uMin <= uFilt;
        end
        if (currentOverRange && !overLatched) begin
          overLatched <= 1'b1;
          overEvent   <= 1'b1;
        end
        if (currentUnderRange && !underLatched) begin
          underLatched <= 1'b1;
          underEvent   <= 1'b1;
        end
      end
    end
  end

  // ---------------------------------------------------------------
  // Event status and interrupt
  // ---------------------------------------------------------------
  always @* begin
    next_errStatus = errStatus;
    if (isWrite && addr == `ADDR_ERR_STATUS) begin
      next_errStatus = errStatus & ~wrData[2:0];
    end
    if (setErr) begin
      next_errStatus[`ST_CMDERR] = 1'b1;
    end
    if (overEvent) begin
      next_errStatus[`ST_OVER] = 1'b1;
    end
    if (underEvent) begin
      next_errStatus[`ST_UNDER] = 1'b1;
    end
  end

  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      errStatus <= 3'h0;
    end else begin
      errStatus <= next_errStatus;
    end
  end

  assign irq = |(errStatus & errMask);

  // ---------------------------------------------------------------
  // Read path
  // ---------------------------------------------------------------
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rdData <= 32'h00000000;
    end else if (!rdStrobe) begin
      rdData <= 32'h00000000;
    end else if (addr == `ADDR_SETPOINT) begin
      rdData <= {12'h000, currentSetpoint};
    end else if (isUpperAddr(addr)) begin
      rdData <= {12'h000, upperBound};
    end else if (addr == `ADDR_LOWER) begin
      rdData <= {12'h000, lowerBound};
    end else if (addr == `ADDR_MEAS_NOW) begin
      rdData <= rangeWord(currentOverRange, currentUnderRange, iFilt);
    end else if (addr == `ADDR_MAX) begin
      rdData <= rangeWord(overLatched, 1'b0, iMax);
    end else if (addr == `ADDR_MIN) begin
      rdData <= rangeWord(1'b0, underLatched, iMin);
    end else if (addr == `ADDR_CAPTURE) begin
      rdData <= {31'h00000000, captureOn};
    end else if (addr == `ADDR_FILTER) begin
      rdData <= {29'h00000000, filterSel};
    end else if (addr == `ADDR_ERR_STATUS) begin
      rdData <= {29'h00000000, errStatus};
    end else if (addr == `ADDR_ERR_MASK) begin
      rdData <= {29'h00000000, errMask};
    end else if (addr == `ADDR_CONTROL) begin
      rdData <= {31'h00000000, analogControl};
    end else if (addr == `ADDR_VOLT_NOW) begin
      rdData <= ext(uFilt);
    end else if (addr == `ADDR_VMAX) begin
      rdData <= ext(uMax);
    end else if (addr == `ADDR_VMIN) begin
      rdData <= ext(uMin);
    end else begin
      rdData <= 32'h00000000;
    end
  end
endmodule

//--- bench/current_cmd_props.sv
// Assertions on the ports of the current command block.
`timescale 1ns/1ps
`include "current_cmd_regs.vh"
module current_cmd_props (
  input wire        clk,
  input wire        rst_n,
  input wire [3:0]  addr,
  input wire [31:0] wrData,
  input wire        wrStrobe,
  input wire        rdStrobe,
  input wire [31:0] rdData,
  input wire        interfaceClear,
  input wire [19:0] currentSetpoint,
  input wire        analogControl,
  input wire        interfaceReinit
);
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  property p_reinit;
    interfaceClear |=> interfaceReinit;
  endproperty
  a_reinit: assert property (p_reinit) else $error("no reinit");
  property p_ifcKeep;
    interfaceClear && !wrStrobe |=> $stable(currentSetpoint)
      && $stable(analogControl);
  endproperty
  a_ifcKeep: assert property (p_ifcKeep) else $error("clear moved");
  property p_spHold;
    !($past(wrStrobe) && $past(addr) == 4'h0) |-> $stable(currentSetpoint);
  endproperty
  a_spHold: assert property (p_spHold) else $error("setpoint moved");
  property p_spExact;
    wrStrobe && addr == 4'h0 |=> $stable(currentSetpoint)
      || currentSetpoint == $past(wrData[19:0]);
  endproperty
  a_spExact: assert property (p_spExact) else $error("bad value");
  property p_spNom;
    wrStrobe && addr == 4'h0 && wrData[19:0] > `I_NOM
      |=> $stable(currentSetpoint);
  endproperty
  a_spNom: assert property (p_spNom) else $error("above nominal");
  property p_analog;
    wrStrobe && addr == 4'hB |=> analogControl == $past(wrData[0]);
  endproperty
  a_analog: assert property (p_analog) else $error("analog bit");
  property p_anHold;
    $changed(analogControl) |-> $past(wrStrobe) && $past(addr) == 4'hB;
  endproperty
  a_anHold: assert property (p_anHold) else $error("analog moved");
  property p_rdSet;
    rdStrobe && addr == 4'h0 |=> rdData == {12'h000, $past(currentSetpoint)};
  endproperty
  a_rdSet: assert property (p_rdSet) else $error("setpoint read");
  c_ifc: cover property (interfaceClear ##1 interfaceReinit);
  c_set: cover property (wrStrobe && addr == 4'h0
    ##1 $changed(currentSetpoint));
  c_an: cover property (analogControl && wrStrobe && addr == 4'h0);
endmodule
bind current_setpoint_cmds current_cmd_props u_props (
  .clk(clk), .rst_n(rst_n), .addr(addr), .wrData(wrData),
  .wrStrobe(wrStrobe), .rdStrobe(rdStrobe), .rdData(rdData),
  .interfaceClear(interfaceClear), .currentSetpoint(currentSetpoint),
  .analogControl(analogControl), .interfaceReinit(interfaceReinit));

//--- bench/meas_frontend.sv
// Model of the measurement front end and the bus clear line.
`timescale 1ns/1ps
module meas_frontend (
  input  wire               clk,
  input  wire               overReq,
  input  wire               underReq,
  input  wire               clearReq,
  input  wire signed [17:0] levelReq,
  output reg  signed [17:0] currentRaw = 0,
  output reg  signed [17:0] voltageRaw = 0,
  output reg                currentOverRange = 0,
  output reg                currentUnderRange = 0,
  output reg                interfaceClear = 0
);
  always @(posedge clk) begin
    currentRaw        <= levelReq;
    voltageRaw        <= levelReq >>> 1;
    currentOverRange  <= overReq;
    currentUnderRange <= underReq;
    interfaceClear    <= clearReq;
  end
endmodule

//--- bench/current_setpoint_cmds_tb.sv
// Self-checking bench for the current command block.
`timescale 1ns/1ps
`include "current_cmd_regs.vh"
module current_setpoint_cmds_tb;
  logic clk = 0, rst_n = 0, wrStrobe = 0, rdStrobe = 0, rdPend = 0;
  logic overReq = 0, underReq = 0, clearReq = 0, analog = 0, errExp = 0;
  logic [3:0] addr = 0;
  logic [31:0] wrData = 0, expNow;
  logic signed [17:0] levelReq = 0;
  logic [19:0] sp = 0, up = `I_NOM, lo = 0, filt = 3, d;
  wire [31:0] rdData;
  wire signed [17:0] currentRaw, voltageRaw;
  wire [19:0] currentSetpoint;
  wire currentOverRange, currentUnderRange, interfaceClear;
  wire analogControl, interfaceReinit, irq;
  logic [31:0] expQ[$];
  string nameQ[$], nameNow;
  integer err_count = 0, checked = 0, cycles = 0, seed, i;
  current_setpoint_cmds DUT (.clk(clk), .rst_n(rst_n), .addr(addr),
    .wrData(wrData), .wrStrobe(wrStrobe), .rdStrobe(rdStrobe),
    .rdData(rdData), .currentRaw(currentRaw), .voltageRaw(voltageRaw),
    .currentOverRange(currentOverRange), .interfaceClear(interfaceClear),
    .currentUnderRange(currentUnderRange), .irq(irq),
    .currentSetpoint(currentSetpoint), .analogControl(analogControl),
    .interfaceReinit(interfaceReinit));
  meas_frontend u_front (.clk(clk), .overReq(overReq), .underReq(underReq),
    .clearReq(clearReq), .levelReq(levelReq), .currentRaw(currentRaw),
    .voltageRaw(voltageRaw), .currentOverRange(currentOverRange),
    .currentUnderRange(currentUnderRange), .interfaceClear(interfaceClear));
  always #25 clk = ~clk;
  task final_report;
    begin
      $display("checks %0d errors %0d", checked, err_count);
      if (err_count == 0 && checked > 0) $display("RESULT: PASS");
      else $display("RESULT: FAIL");
      $finish;
    end
  endtask
  task cmp(input string n, input logic [31:0] e, input logic [31:0] s);
    begin
      checked = checked + 1;
      if (s !== e) begin
        err_count = err_count + 1;
        $display("CHECK FAILED %s expected %h seen %h", n, e, s);
      end
    end
  endtask
  task op(input logic w, input logic r, input logic [3:0] a,
          input logic [19:0] v);
    begin
      wrStrobe <= w;
      rdStrobe <= r;
      addr     <= a;
      wrData   <= {12'h000, v};
      @(posedge clk);
    end
  endtask
  task rd(input logic [3:0] a, input logic [31:0] e, input string n);
    begin
      expQ.push_back(e);
      nameQ.push_back(n);
      op(0, 1, a, 20'h00000);
    end
  endtask
  task put(input logic [3:0] a, input logic [19:0] v);
    logic ok;
    begin
      ok = 1;
      case (a)
        4'h0: ok = analog ? v <= `I_NOM : v >= lo && v <= up;
        4'h1, 4'h3: ok = v >= sp && v <= `I_NOM;
        4'h2: ok = v <= sp;
        4'h8: ok = v >= 1 && v <= 4;
        4'hB: analog = v[0];
        default: ok = 1;
      endcase
      if (ok && a == 4'h0) sp = v;
      if (ok && (a == 4'h1 || a == 4'h3)) up = v;
      if (ok && a == 4'h2) lo = v;
      if (ok && a == 4'h8) filt = v;
      errExp = errExp | !ok;
      op(1, 0, a, v);
    end
  endtask
  task chk;
    begin
      rd(4'h0, {12'h000, sp}, "setpoint");
      rd(4'h1, {12'h000, up}, "upper");
      rd(4'h2, {12'h000, lo}, "lower");
      rd(4'h3, {12'h000, up}, "legacy");
      rd(4'h8, {12'h000, filt}, "filter");
      rd(4'h9, {29'h0, errExp, 2'h0}, "status");
      cmp("irq", {31'h0, errExp}, {31'h0, irq});
      cmp("setpointOut", {12'h000, sp}, {12'h000, currentSetpoint});
      cmp("analog", {31'h0, analog}, {31'h0, analogControl});
      op(1, 0, 4'h9, 20'h00007);
      errExp = 0;
      op(0, 0, 4'h0, 20'h00000);
    end
  endtask
  always @(posedge clk) begin
    cycles = cycles + 1;
    if (cycles == 45000) begin
      err_count = err_count + 1;
      final_report;
    end
    if (rdPend) begin
      expNow = expQ.pop_front();
      nameNow = nameQ.pop_front();
      cmp(nameNow, expNow, rdData);
    end
    rdPend <= rdStrobe;
  end
  initial begin
    seed = 32'h48CE1E8F;
    repeat (6) @(posedge clk);
    rst_n <= 1;
    op(1, 0, 4'hA, 20'h00004);
    chk;
    put(4'h0, 20'd1000);
    put(4'h1, 20'd999);
    chk;
    put(4'h1, 20'd5000);
    put(4'h3, 20'd4000);
    put(4'h0, 20'd4001);
    chk;
    put(4'h0, 20'd4000);
    put(4'h2, 20'd4001);
    put(4'h2, 20'd4000);
    put(4'h0, 20'd3999);
    chk;
    for (i = 0; i < 6; i = i + 1) put(4'h8, 20'(i));
    chk;
    put(4'hB, 20'h00001);
    put(4'h0, `I_NOM);
    put(4'h0, 20'd60001);
    chk;
    clearReq <= 1;
    op(0, 0, 4'h0, 20'h00000);
    clearReq <= 0;
    repeat (2) op(0, 0, 4'h0, 20'h00000);
    cmp("reinit", 32'h00000001, {31'h0, interfaceReinit});
    chk;
    put(4'hB, 20'h00000);
    put(4'h1, `I_NOM);
    for (i = 0; i < 24; i = i + 1) begin
      d = 20'($unsigned($random(seed)) % 62000);
      put(4'(i % 3), d);
      chk;
    end
    op(1, 0, 4'h7, 20'h00001);
    overReq <= 1;
    repeat (3) op(0, 0, 4'h0, 20'h00000);
    rd(4'h4, 32'h000F423F, "present");
    overReq <= 0;
    underReq <= 1;
    repeat (3) op(0, 0, 4'h0, 20'h00000);
    rd(4'h5, 32'h000F423F, "max");
    rd(4'h6, 32'hFFF0BDC1, "min");
    underReq <= 0;
    op(1, 0, 4'h7, 20'h00003);
    op(0, 0, 4'h0, 20'h00000);
    rd(4'h5, 32'h00000000, "maxReset");
    rd(4'h6, 32'h00000000, "minReset");
    op(1, 0, 4'h7, 20'h00000);
    overReq <= 1;
    repeat (3) op(0, 0, 4'h0, 20'h00000);
    rd(4'h5, 32'h00000000, "maxFrozen");
    overReq <= 0;
    put(4'h8, 20'h00001);
    op(1, 0, 4'h7, 20'h00003);
    levelReq <= 18'h01F40;
    op(0, 0, 4'h0, 20'h00000);
    repeat (41000) @(posedge clk);
    rd(4'h4, 32'h00001F40, "presentLevel");
    rd(4'h5, 32'h00001F40, "maxLevel");
    rd(4'h6, 32'h00000000, "minLevel");
    rd(4'hD, 32'h00000FA0, "voltMax");
    op(1, 0, 4'h7, 20'h00003);
    rd(4'h6, 32'h00001F40, "minLoad");
    rd(4'h9, 32'h00000003, "rangeStatus");
    op(1, 0, 4'h9, 20'h00007);
    repeat (3) op(0, 0, 4'h0, 20'h00000);
    final_report;
  end
endmodule
